// [core/sar_ctrl.v]
// conversion control of a 16-bit successive approximation converter
`timescale 1ns/1ns
`include "sar_regs.vh"

// Functional notes
// - falling start input ends acquisition, starts conversion
// - acquisition: array on input, dummy on ground
// - conversion: open samplers, array to reference ground
// - msb-first binary search over sixteen bits
// - form output code, then drop busy
// - result ready at end of same conversion
// - fast mode supports one million samples/second
// - normal mode 800 kSPS, no interval limit
// - low-power mode powers down between conversions
// - coding select: straight binary or twos complement
// - twos complement is binary with msb inverted
// - over-range gives full-scale code
// - under-range gives minimum code
// - busy high from start until result latched
// - low-power: start held low converts after acquisition
// - reset input aborts conversion in progress
// - power-down finishes current, then inhibits conversions
module sar_ctrl
(
    input  wire        i_clk_sys,      // system clock, 100 MHz
    input  wire        i_rst_n,        // async reset, active low
    input  wire [31:0] haddr,          // ahb address
    input  wire [1:0]  htrans,         // ahb transfer type
    input  wire        hwrite,         // ahb write
    input  wire [2:0]  hsize,          // ahb size
    input  wire [31:0] hwdata,         // ahb write data
    input  wire        hsel,           // ahb slave select
    input  wire        hready,         // ahb bus ready
    output wire [31:0] hrdata,         // ahb read data
    output wire        hreadyout,      // ahb slave ready
    output wire        hresp,          // ahb response, always okay
    input  wire        i_convert_start_n, // conversion start pin, falling edge
    input  wire        i_cmp_hi,       // comparator output pin
    input  wire        i_over_range,   // analog over-range detect pin
    input  wire        i_under_range,  // analog under-range detect pin
    output wire [15:0] o_array_switch, // array elements: 1 reference, 0 ref ground
    output reg         o_array_sample_switch, // array top plate sampling switch closed
    output reg         o_dummy_sample_switch, // dummy element sampling switch closed
    output reg         o_array_on_input,      // array bottoms tied to analog input
    output reg         o_dummy_on_ground,     // dummy tied to input ground
    output reg         o_analog_power,        // analog core powered
    output reg         o_busy,         // conversion in progress
    output reg  [15:0] o_result        // latched output code
);

    // ==========================================================================
    // states
    localparam [2:0] ST_OFF  = 3'h0;
    localparam [2:0] ST_ACQ  = 3'h1;
    localparam [2:0] ST_CONV = 3'h2;
    localparam [2:0] ST_FORM = 3'h3;
    localparam [2:0] ST_WAKE = 3'h4;

    reg  [2:0]  state_q;
    reg  [5:0]  ctrl_q;
    reg  [1:0]  cvs_sync_q;
    reg  [1:0]  cmp_sync_q;
    reg  [1:0]  ovr_sync_q;
    reg  [1:0]  und_sync_q;
    reg         cvs_prev_q;
    reg  [8:0]  acq_cnt_q;
    reg  [`SAR_CNT_W-1:0] idle_cnt_q;
    reg         stale_q;
    reg         stale_res_q;
    reg         valid_q;
    reg         ovr_res_q;
    reg         und_res_q;
    reg  [15:0] raw_q;
    reg  [15:0] count_q;
    reg  [7:0]  ap_addr_q;
    reg         ap_wr_q;
    reg         ap_rd_q;
    reg  [31:0] rdata_q;
    wire        srch_done;
    wire [15:0] srch_code;
    wire        start_fall;
    wire        start_low;
    wire        go;
    wire        abort;
    wire [1:0]  mode;
    reg  [15:0] code_bin;
    reg  [15:0] code_out;
    reg  [2:0]  state_d;

    assign mode  = ctrl_q[`SAR_CTRL_MODE_HI:`SAR_CTRL_MODE_LO];
    assign abort = ctrl_q[`SAR_CTRL_RESET];

    // ==========================================================================
    // pin synchronisers: first stage read only by the second
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cvs_sync_q <= 2'h3;
            cmp_sync_q <= 2'h0;
            ovr_sync_q <= 2'h0;
            und_sync_q <= 2'h0;
            cvs_prev_q <= 1'b1;
        end
        else
        begin
            cvs_sync_q <= {cvs_sync_q[0], i_convert_start_n};
            cmp_sync_q <= {cmp_sync_q[0], i_cmp_hi};
            ovr_sync_q <= {ovr_sync_q[0], i_over_range};
            und_sync_q <= {und_sync_q[0], i_under_range};
            cvs_prev_q <= cvs_sync_q[1];
        end
    end

    // software start bit acts as a falling edge on the pin
    assign start_fall = (cvs_prev_q & ~cvs_sync_q[1]) | ctrl_q[`SAR_CTRL_START];
    assign start_low  = ~cvs_sync_q[1];
    // low-power mode also accepts a start already held low after acquisition
    assign go = (state_q == ST_ACQ) && (acq_cnt_q == 9'h000) && !abort &&
                (start_fall || ((mode == `SAR_MODE_LOWPWR) && start_low));

    // ==========================================================================
    // main sequencer
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_OFF:  if (!ctrl_q[`SAR_CTRL_PWRDN]) state_d = ST_WAKE;
            ST_WAKE: state_d = ST_ACQ;
            ST_ACQ:
            begin
                if (ctrl_q[`SAR_CTRL_PWRDN])
                    state_d = ST_OFF;
                else if (go)
                    state_d = ST_CONV;
            end
            ST_CONV: if (srch_done) state_d = ST_FORM;
            ST_FORM: state_d = ctrl_q[`SAR_CTRL_PWRDN] ? ST_OFF : ST_ACQ;
            default: state_d = ST_ACQ;
        endcase
        if (abort)
            state_d = ST_ACQ;
    end

    // over-range and under-range clamp before coding
    always @*
    begin
        code_bin = srch_code;
        if (ovr_sync_q[1])
            code_bin = `SAR_CODE_FULL;
        else if (und_sync_q[1])
            code_bin = `SAR_CODE_ZERO;
        code_out = code_bin;
        if (ctrl_q[`SAR_CTRL_CODING])
            code_out = code_bin ^ `SAR_CODE_TOP;
    end

    // ==========================================================================
    // state, switches, busy and result
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q               <= ST_ACQ;
            acq_cnt_q             <= 9'h000;
            o_array_sample_switch <= 1'b1;
            o_dummy_sample_switch <= 1'b1;
            o_array_on_input      <= 1'b1;
            o_dummy_on_ground     <= 1'b1;
            o_analog_power        <= 1'b1;
            o_busy                <= 1'b0;
            o_result              <= `SAR_CODE_ZERO;
            raw_q                 <= `SAR_CODE_ZERO;
            valid_q               <= 1'b0;
            stale_res_q           <= 1'b0;
            ovr_res_q             <= 1'b0;
            und_res_q             <= 1'b0;
            count_q               <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            // acquisition time counts down after each conversion or wake
            if (state_d == ST_ACQ && state_q != ST_ACQ)
                acq_cnt_q <= `SAR_ACQ_LOAD;
            else if (acq_cnt_q != 9'h000)
                acq_cnt_q <= acq_cnt_q - 9'h001;
            // tracking in acquisition, frozen on reference ground in conversion
            o_array_sample_switch <= (state_d == ST_ACQ);
            o_dummy_sample_switch <= (state_d == ST_ACQ);
            o_array_on_input      <= (state_d == ST_ACQ);
            o_dummy_on_ground     <= (state_d == ST_ACQ);
            // low-power mode idles the analog core except around conversion;
            // the cycle entering acquisition still sees the old count, so skip it
            o_analog_power <= (state_d != ST_OFF) &&
                              !((mode == `SAR_MODE_LOWPWR) && state_q == ST_ACQ &&
                                state_d == ST_ACQ && acq_cnt_q == 9'h000 &&
                                !start_low);
            o_busy <= (state_d == ST_CONV) || (state_d == ST_FORM);
            // latch in the form cycle, busy drops the cycle after
            if (state_q == ST_CONV && srch_done && !abort)
            begin
                o_result    <= code_out;
                raw_q       <= srch_code;
                valid_q     <= 1'b1;
                stale_res_q <= stale_q && (mode == `SAR_MODE_FAST);
                ovr_res_q   <= ovr_sync_q[1];
                und_res_q   <= und_sync_q[1];
                count_q     <= count_q + 16'h0001;
            end
        end
    end

    // idle timer flags fast-mode results after a long gap
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            idle_cnt_q <= {`SAR_CNT_W{1'b0}};
            stale_q    <= 1'b1;
        end
        else if (go)
        begin
            idle_cnt_q <= {`SAR_CNT_W{1'b0}};
        end
        else if (srch_done)
        begin
            stale_q    <= 1'b0;
        end
        else if (idle_cnt_q == `SAR_STALE_LIM)
        begin
            stale_q    <= 1'b1;
        end
        else
        begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    // three clocks per bit for the comparator synchroniser: with acquisition, under 1 us
    sar_search u_search
    (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_abort   (abort),
        .i_go      (go),
        .i_cmp_hi  (cmp_sync_q[1]),
        .o_trial   (o_array_switch),
        .o_done    (srch_done),
        .o_code    (srch_code)
    );

    // ==========================================================================
    // ahb-lite slave, zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ap_addr_q <= 8'h00;
            ap_wr_q   <= 1'b0;
            ap_rd_q   <= 1'b0;
        end
        else if (hready)
        begin
            ap_addr_q <= haddr[7:0];
            ap_wr_q   <= hsel & htrans[1] & hwrite;
            ap_rd_q   <= hsel & htrans[1] & ~hwrite;
        end
    end

    // read data registered at the address phase so it stands in the data phase
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rdata_q <= 32'h00000000;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (haddr[7:0])
                `SAR_OFS_CTRL:   rdata_q <= {26'h0000000, ctrl_q};
                `SAR_OFS_STATUS: rdata_q <= {26'h0000000, und_res_q, ovr_res_q,
                                  (state_q == ST_OFF), stale_res_q, valid_q, o_busy};
                `SAR_OFS_RESULT: rdata_q <= {16'h0000, o_result};
                `SAR_OFS_RAW:    rdata_q <= {16'h0000, raw_q};
                `SAR_OFS_COUNT:  rdata_q <= {16'h0000, count_q};
                default:         rdata_q <= 32'h00000000;
            endcase
        end
    end

    // control writes; start self-clears, reset bit stays until cleared
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ctrl_q <= `SAR_CTRL_RST_VAL;
        else
        begin
            ctrl_q[`SAR_CTRL_START] <= 1'b0;
            if (ap_wr_q && ap_addr_q == `SAR_OFS_CTRL)
                ctrl_q <= hwdata[`SAR_CTRL_WIDTH-1:0];
        end
    end

endmodule // sar_ctrl

// [include/sar_regs.vh]
// register map, field positions, reset values and timing counts for the sar control block
`ifndef SAR_CTRL_REGS_VH
`define SAR_CTRL_REGS_VH

// ==========================================================================
// register byte offsets
`define SAR_OFS_CTRL     8'h00
`define SAR_OFS_STATUS   8'h04
`define SAR_OFS_RESULT   8'h08
`define SAR_OFS_RAW      8'h0C
`define SAR_OFS_COUNT    8'h10

// ==========================================================================
// control fields
`define SAR_CTRL_MODE_LO    0
`define SAR_CTRL_MODE_HI    1
`define SAR_CTRL_CODING     2
`define SAR_CTRL_PWRDN      3
`define SAR_CTRL_RESET      4
`define SAR_CTRL_START      5
`define SAR_CTRL_WIDTH      6
`define SAR_CTRL_RST_VAL    6'h00

// ==========================================================================
// speed and power modes
`define SAR_MODE_NORMAL  2'h0
`define SAR_MODE_LOWPWR  2'h1
`define SAR_MODE_FAST    2'h2

// ==========================================================================
// status fields
`define SAR_ST_BUSY      0
`define SAR_ST_VALID     1
`define SAR_ST_STALE     2
`define SAR_ST_PWRDN     3
`define SAR_ST_OVER      4
`define SAR_ST_UNDER     5

// ==========================================================================
// conversion geometry
`define SAR_BITS         16
`define SAR_MSB_IDX      4'hF
`define SAR_CODE_ZERO    16'h0000
`define SAR_CODE_FULL    16'hFFFF
`define SAR_CODE_TOP     16'h8000

// ==========================================================================
// timing: 100 MHz clock, 10 ns
`define SAR_CLK_NS          10
`define SAR_ACQ_NS          300
`define SAR_ACQ_CYC         ((`SAR_ACQ_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_STALE_MS        1
`define SAR_STALE_CYC       (`SAR_STALE_MS * 1000000 / `SAR_CLK_NS)
`define SAR_CNT_W           17
// sized copies of the two counts above, for the counters; keep them in step
`define SAR_ACQ_LOAD        9'h01E
`define SAR_STALE_LIM       17'h186A0
// a comparator decision crosses the two-stage synchroniser before it is used
`define SAR_CMP_WAIT        2'h2

`endif

// [core/sar_search.v]
// successive approximation bit search over a 16-element weighted array
`timescale 1ns/1ns
`include "sar_regs.vh"

module sar_search
(
    input  wire        i_clk_sys,     // system clock
    input  wire        i_rst_n,       // async reset, active low
    input  wire        i_abort,       // synchronous abort
    input  wire        i_go,          // pulse: start a search
    input  wire        i_cmp_hi,      // comparator: trial not above input
    output wire [15:0] o_trial,       // array switch pattern under test
    output reg         o_done,        // pulse: search complete
    output reg  [15:0] o_code         // searched straight binary code
);

    reg  [15:0] bits_q;
    reg  [15:0] mask_q;
    reg  [1:0]  ph_q;
    reg         run_q;

    // trial = kept bits plus the bit now under test
    assign o_trial = bits_q | mask_q;

    // ==========================================================================
    // search steps, one bit per three clocks from the msb
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bits_q <= `SAR_CODE_ZERO;
            mask_q <= `SAR_CODE_ZERO;
            ph_q   <= 2'h0;
            run_q  <= 1'b0;
            o_done <= 1'b0;
            o_code <= `SAR_CODE_ZERO;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_abort)
            begin
                run_q  <= 1'b0;
                ph_q   <= 2'h0;
                mask_q <= `SAR_CODE_ZERO;
            end
            else if (i_go)
            begin
                bits_q <= `SAR_CODE_ZERO;
                mask_q <= `SAR_CODE_TOP;
                ph_q   <= 2'h0;
                run_q  <= 1'b1;
            end
            else if (run_q && ph_q != `SAR_CMP_WAIT)
            begin
                // judging earlier would use the answer to the previous trial
                ph_q <= ph_q + 2'h1;
            end
            else if (run_q)
            begin
                ph_q <= 2'h0;
                // keep the bit when the comparator stays balanced toward input
                if (i_cmp_hi)
                    bits_q <= bits_q | mask_q;
                mask_q <= mask_q >> 1;
                if (mask_q[0])
                begin
                    run_q  <= 1'b0;
                    o_done <= 1'b1;
                    o_code <= i_cmp_hi ? (bits_q | mask_q) : bits_q;
                end
            end
        end
    end

endmodule // sar_search

// [testbench/sar_ctrl_chk.sv]
// assertion checker for the sar conversion control ports
`timescale 1ns/1ns
module sar_ctrl_chk
(
    input wire        i_clk_sys,             // system clock
    input wire        i_rst_n,               // async reset, active low
    input wire        o_busy,                // conversion in progress
    input wire [15:0] o_result,              // latched code
    input wire [15:0] o_array_switch,        // trial pattern
    input wire        o_array_sample_switch, // array sampler closed
    input wire        o_dummy_sample_switch, // dummy sampler closed
    input wire        o_array_on_input,      // array on analog input
    input wire        o_dummy_on_ground,     // dummy on input ground
    input wire        o_analog_power         // analog core powered
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // ==================================================================
    // busy length: counts busy cycles, cleared while idle
    logic [7:0] busy_len_q;
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
        if (!i_rst_n)
            busy_len_q <= 8'h00;
        else
            busy_len_q <= o_busy ? busy_len_q + 8'h01 : 8'h00;
    // ==================================================================
    // properties
    property p_hold_on_start;
        $rose(o_busy) |-> !o_array_sample_switch && !o_dummy_sample_switch;
    endproperty
    a_hold_on_start: assert property (p_hold_on_start)
        else $error("samplers still closed at conversion start");
    property p_conv_off_input;
        o_busy |-> !o_array_on_input && !o_dummy_on_ground;
    endproperty
    a_conv_off_input: assert property (p_conv_off_input)
        else $error("array left on input during conversion");
    property p_acq_on_input;
        $fell(o_busy) && o_analog_power |-> ##[0:2] (o_array_on_input && o_dummy_on_ground);
    endproperty
    a_acq_on_input: assert property (p_acq_on_input)
        else $error("array not back on input after conversion");
    property p_switch_pair;
        o_array_sample_switch == o_dummy_sample_switch;
    endproperty
    a_switch_pair: assert property (p_switch_pair)
        else $error("array and dummy samplers disagree");
    property p_msb_first;
        $rose(o_busy) |-> ##[0:2] (o_array_switch == 16'h8000);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("search did not open with the top bit");
    property p_result_then_idle;
        $changed(o_result) |-> o_busy ##1 !o_busy;
    endproperty
    a_result_then_idle: assert property (p_result_then_idle)
        else $error("result changed outside the end of a conversion");
    property p_full_search;
        $changed(o_result) |-> busy_len_q >= 8'h30;
    endproperty
    a_full_search: assert property (p_full_search)
        else $error("result formed before sixteen steps");
    property p_busy_bounded;
        o_busy |-> busy_len_q <= 8'h32;
    endproperty
    a_busy_bounded: assert property (p_busy_bounded)
        else $error("busy stuck high");
    // main scenarios seen
    c_done: cover property ($fell(o_busy));
    c_full: cover property ($changed(o_result) && o_result == 16'hFFFF);
    c_mid: cover property ($changed(o_result) && o_result == 16'h8000);
endmodule // sar_ctrl_chk

bind sar_ctrl sar_ctrl_chk i_chk
(
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .o_busy(o_busy), .o_result(o_result),
    .o_array_switch(o_array_switch), .o_array_sample_switch(o_array_sample_switch),
    .o_dummy_sample_switch(o_dummy_sample_switch), .o_array_on_input(o_array_on_input),
    .o_dummy_on_ground(o_dummy_on_ground), .o_analog_power(o_analog_power)
);

// [testbench/sar_afe_model.sv]
// analog front end and comparator standing behind the array switches
`timescale 1ns/1ns
module sar_afe_model
(
    input  wire        i_clk_sys,      // system clock
    input  wire        i_tracking,     // sampler closed, no decision
    input  wire [15:0] i_array_switch, // trial pattern from the block
    input  int         i_vin_lsb,      // held input in code steps
    output logic       o_cmp_hi,       // trial not above input
    output logic       o_over_range,   // input above reference span
    output logic       o_under_range   // input below input ground
);
    logic flip_q = 1'b0;
    // while tracking the comparator output is meaningless, so it wanders
    always @(posedge i_clk_sys)
        flip_q <= ~flip_q;
    // one trial step weighs reference over 65536
    always_comb o_cmp_hi = i_tracking ? flip_q : (int'(i_array_switch) <= i_vin_lsb);
    always_comb o_over_range = i_vin_lsb > 65535;
    always_comb o_under_range = i_vin_lsb < 0;
endmodule // sar_afe_model

// [testbench/test_sar_conversion_control.sv]
// self-checking bench for the sar conversion control block
`timescale 1ns/1ns
`include "sar_regs.vh"
module test_sar_conversion_control;
    typedef struct { int v; logic [2:0] ctl; logic [15:0] exp; } sar_row_t;
    logic        clk_sys;
    logic        rst_n;
    logic        hsel;
    logic        hwrite;
    logic        start_n;
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] rd;
    wire  [31:0] hrdata;
    wire  [15:0] array_sw;
    wire  [15:0] result;
    wire         hreadyout, hresp, cmp_hi, over_rng, under_rng;
    wire         samp_a, samp_d, on_in, on_gnd, power, busy;
    int          vin;
    int          miscompares;
    int          tests_run;
    // ctl is {coding, mode}; modes rotate so every mode converts
    sar_row_t    rows [12] = '{
        '{0, 3'h0, 16'h0000}, '{0, 3'h5, 16'h8000},
        '{32768, 3'h2, 16'h8000}, '{32768, 3'h4, 16'h0000},
        '{65535, 3'h1, 16'hFFFF}, '{65535, 3'h6, 16'h7FFF},
        '{70000, 3'h0, 16'hFFFF}, '{70000, 3'h5, 16'h7FFF},
        '{-5, 3'h2, 16'h0000}, '{-5, 3'h4, 16'h8000},
        '{1234, 3'h1, 16'h04D2}, '{32769, 3'h6, 16'h0001}};
    // ==================================================================
    // design and far side
    sar_ctrl i_dut
    (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .i_convert_start_n(start_n), .i_cmp_hi(cmp_hi), .i_over_range(over_rng),
        .i_under_range(under_rng), .o_array_switch(array_sw),
        .o_array_sample_switch(samp_a), .o_dummy_sample_switch(samp_d),
        .o_array_on_input(on_in), .o_dummy_on_ground(on_gnd), .o_analog_power(power),
        .o_busy(busy), .o_result(result)
    );
    sar_afe_model i_afe
    (
        .i_clk_sys(clk_sys), .i_tracking(samp_a), .i_array_switch(array_sw),
        .i_vin_lsb(vin), .o_cmp_hi(cmp_hi), .o_over_range(over_rng),
        .o_under_range(under_rng)
    );
    // ==================================================================
    // tasks; every task but the watchdog's end_of_test is entered just after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (busy !== lvl)
        begin
            miscompares++;
            $display("Error at %0t: busy did not reach %b", $time, lvl);
        end
    endtask
    // full acquisition before each start, busy has already fallen
    task automatic convert(input int v);
        vin <= v;
        repeat (40) @(posedge clk_sys);
        start_n <= 1'b0;
        wait_busy(1'b1, 10);
        start_n <= 1'b1;
        wait_busy(1'b0, 80);
        @(posedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==================================================================
    // clock, watchdog, main sequence
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        #300000;
        miscompares++;
        end_of_test();
    end
    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        start_n = 1'b1;
        vin = 0;
        miscompares = 0;
        tests_run = 0;
        repeat (10) @(posedge clk_sys);
        cmp({busy, result}, 17'h00000);
        cmp({samp_a, samp_d, on_in, on_gnd, power}, 5'h1F);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // unmapped place reads zero and ignores writes
        ahb(1'b1, 32'h20, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h20, 32'h0);
        cmp(rd, 32'h0);
        // fast rows never idle past 1 ms, so no result is flagged stale
        foreach (rows[i])
        begin
            ahb(1'b1, {24'h0, `SAR_OFS_CTRL}, {29'h0, rows[i].ctl});
            convert(rows[i].v);
            cmp(result, rows[i].exp);
            ahb(1'b0, {24'h0, `SAR_OFS_RESULT}, 32'h0);
            cmp(rd, {16'h0, rows[i].exp});
        end
        ahb(1'b0, {24'h0, `SAR_OFS_COUNT}, 32'h0);
        cmp(rd, 32'h0000000C);
        ahb(1'b0, {24'h0, `SAR_OFS_STATUS}, 32'h0);
        cmp(rd, 32'h00000002);
        cmp(hresp, 1'b0);
        // low power: idle powers down, start held low converts after acquisition
        ahb(1'b1, {24'h0, `SAR_OFS_CTRL}, 32'h1);
        convert(100);
        start_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        cmp(busy, 1'b0);
        wait_busy(1'b1, 60);
        cmp(busy, 1'b1);
        start_n <= 1'b1;
        wait_busy(1'b0, 80);
        @(posedge clk_sys);
        cmp(result, 16'h0064);
        repeat (40) @(posedge clk_sys);
        cmp(power, 1'b0);
        ahb(1'b1, {24'h0, `SAR_OFS_CTRL}, 32'h0);
        repeat (40) @(posedge clk_sys);
        cmp(power, 1'b1);
        // power down mid conversion: finish it, then refuse starts
        vin <= 500;
        start_n <= 1'b0;
        wait_busy(1'b1, 10);
        start_n <= 1'b1;
        ahb(1'b1, {24'h0, `SAR_OFS_CTRL}, 32'h8);
        wait_busy(1'b0, 80);
        @(posedge clk_sys);
        cmp(result, 16'h01F4);
        repeat (40) @(posedge clk_sys);
        start_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        cmp({busy, power}, 2'h0);
        start_n <= 1'b1;
        ahb(1'b1, {24'h0, `SAR_OFS_CTRL}, 32'h0);
        // abort mid conversion: busy drops early, old result kept
        vin <= 700;
        repeat (40) @(posedge clk_sys);
        start_n <= 1'b0;
        wait_busy(1'b1, 10);
        start_n <= 1'b1;
        ahb(1'b1, {24'h0, `SAR_OFS_CTRL}, 32'h10);
        wait_busy(1'b0, 6);
        cmp(busy, 1'b0);
        cmp(result, 16'h01F4);
        ahb(1'b1, {24'h0, `SAR_OFS_CTRL}, 32'h0);
        // software start bit converts like a pin edge once abort is lifted
        repeat (40) @(posedge clk_sys);
        ahb(1'b1, {24'h0, `SAR_OFS_CTRL}, 32'h20);
        wait_busy(1'b1, 10);
        wait_busy(1'b0, 80);
        @(posedge clk_sys);
        cmp(result, 16'h02BC);
        end_of_test();
    end
endmodule // test_sar_conversion_control
